/* inc/irt_pkg.sv */
package irt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_LOAD    = 8'h04;
  localparam logic [7:0] OFF_CMD     = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STS = 8'h10;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h18;

  // Field widths and positions
  localparam int CNT_W        = 9;
  localparam int TMR_W        = 10;
  localparam int CTRL_W       = 3;
  localparam int IRQ_W        = 3;
  localparam int STS_W        = 4;
  localparam int CMD_HALT_BIT = 0;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_STOP     = 1;
  localparam int IRQ_WAKE     = 2;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [TMR_W-1:0]  TMR_RST  = 10'h000;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 3'h0;

  // Timing: oscillator periods per machine cycle and per carrier period
  localparam int          OSC_PER_MC = 8;
  localparam int          MC_W       = $clog2(OSC_PER_MC);
  localparam logic [MC_W-1:0] MC_LAST = MC_W'(OSC_PER_MC - 1);
  localparam int          CAR_DIV_LO = 8;
  localparam int          CAR_DIV_HI = 12;
  localparam int          CAR_W      = 4;
  localparam logic [CAR_W-1:0] CAR_LAST_LO = CAR_W'(CAR_DIV_LO - 1);
  localparam logic [CAR_W-1:0] CAR_LAST_HI = CAR_W'(CAR_DIV_HI - 1);
  localparam logic [CAR_W-1:0] CAR_HALF_LO = CAR_W'(CAR_DIV_LO / 2);
  localparam logic [CAR_W-1:0] CAR_HALF_HI = CAR_W'(CAR_DIV_HI / 2);

  typedef struct packed {
    logic osc_stop_on_halt;
    logic carrier_freq_select;
    logic run;
  } irt_ctrl_s;

  typedef struct packed {
    logic             carrier_en;
    logic [CNT_W-1:0] count;
  } irt_tmr_s;

  typedef enum logic [3:0] {
    PW_RUN       = 4'b0001,
    PW_WAIT      = 4'b0010,
    PW_STOP_PEND = 4'b0100,
    PW_STOP      = 4'b1000
  } irt_pwr_e;

endpackage

/* src/irt_carrier_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// Free-running carrier divider, fosc/8 or fosc/12, about half duty
module irt_carrier_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic osc_en,
  input  wire logic div12,
  // Carrier
  output logic      wave
);

  logic [irt_pkg::CAR_W-1:0] phase;
  logic [irt_pkg::CAR_W-1:0] last;
  logic [irt_pkg::CAR_W-1:0] half;

  assign last = div12 ? irt_pkg::CAR_LAST_HI : irt_pkg::CAR_LAST_LO; // RULE_17
  assign half = div12 ? irt_pkg::CAR_HALF_HI : irt_pkg::CAR_HALF_LO;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (osc_en) begin
      if (phase >= last) begin
        phase <= '0;
      end else begin
        phase <= phase + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wave <= 1'b0;
    end else if (osc_en) begin
      wave <= (phase < half);
    end
  end

endmodule // irt_carrier_gen

`default_nettype wire

/* src/irt_timer_top.sv */
// Contract
// RULE_01: Ten timer bits: nine count, one carrier latch
// RULE_02: Decrement once per eight oscillator periods
// RULE_03: Stop at zero and flag completion
// RULE_04: Completion releases a halt waiting on timer
// RULE_05: Reload after completion continues without carrier glitch
// RULE_06: Software loads interval/8 minus one
// RULE_07: Carrier only while running with latch set
// RULE_08: Carrier ends at zero; idle pin low
// RULE_09: Indicator is inverted carrier activity
// RULE_10: Oscillator stop waits for count end
// RULE_11: Control register bit governs timer run
// RULE_12: Reset: carrier low, indicator high, timer cleared
// RULE_13: Low-supply reset drives indicator low
// RULE_14: First and last carrier pulses may shorten
// RULE_15: Stop mode freezes all clocked timer logic
// RULE_16: Run bit zero stops, one counts
// RULE_17: Select bit picks fosc/8 or fosc/12
// RULE_18: One load writes count and latch together
`timescale 1ns/1ps
`default_nettype none

module irt_timer_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins
  input  wire logic        low_volt_reset,
  input  wire logic        wake_pin,
  output logic             carrier_out_pin,
  output logic             tx_active_n,
  // Core side
  output logic             core_halted,
  output logic             core_wake,
  output logic             osc_running,
  output logic             irq
);

  function automatic logic irt_hit(input logic [31:0] a,
                                   input logic [7:0]  off);
    irt_hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  // Pin synchronisers
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic       lvd;
  logic       wake_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
    end else begin
      pin_s1 <= {wake_pin, low_volt_reset};
      pin_s2 <= pin_s1;
    end
  end

  assign lvd    = pin_s2[0];
  assign wake_s = pin_s2[1];

  // Block-wide clear: all-clear pin or low-supply detector
  logic clr;
  assign clr = !rst_n || lvd;

  // AHB address phase capture
  logic        ap_valid;
  logic        ap_write;
  logic [31:0] ap_addr;
  logic        take;
  logic        wr;

  assign take      = hready && hsel && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 32'h00000000;
    end else if (hready) begin
      ap_valid <= take;
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  assign wr = ap_valid && ap_write;

  logic wr_ctrl;
  logic wr_load;
  logic wr_cmd;
  logic wr_iclr;
  logic wr_ien;

  assign wr_ctrl = wr && irt_hit(ap_addr, irt_pkg::OFF_CTRL);
  assign wr_load = wr && irt_hit(ap_addr, irt_pkg::OFF_LOAD);
  assign wr_cmd  = wr && irt_hit(ap_addr, irt_pkg::OFF_CMD);
  assign wr_iclr = wr && irt_hit(ap_addr, irt_pkg::OFF_IRQ_CLR);
  assign wr_ien  = wr && irt_hit(ap_addr, irt_pkg::OFF_IRQ_EN);

  // Control register
  irt_pkg::irt_ctrl_s ctrl;

  always_ff @(posedge clk) begin
    if (clr) begin
      ctrl <= irt_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= hwdata[irt_pkg::CTRL_W-1:0]; // RULE_11
    end
  end

  // Power state
  irt_pkg::irt_pwr_e pwr;
  irt_pkg::irt_pwr_e next_pwr;
  logic              halt_cmd;
  logic              running;
  logic              done;

  assign halt_cmd = wr_cmd && hwdata[irt_pkg::CMD_HALT_BIT];

  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      irt_pkg::PW_RUN: begin
        if (halt_cmd) begin
          if (!ctrl.osc_stop_on_halt) begin
            next_pwr = irt_pkg::PW_WAIT;
          end else if (running) begin
            next_pwr = irt_pkg::PW_STOP_PEND; // RULE_10
          end else begin
            next_pwr = irt_pkg::PW_STOP;
          end
        end
      end
      irt_pkg::PW_WAIT: begin
        if (done || !running) begin
          next_pwr = irt_pkg::PW_RUN; // RULE_04
        end
      end
      irt_pkg::PW_STOP_PEND: begin
        if (done || !running) begin
          next_pwr = irt_pkg::PW_STOP; // RULE_10
        end
      end
      irt_pkg::PW_STOP: begin
        if (wake_s) begin
          next_pwr = irt_pkg::PW_RUN;
        end
      end
      default: begin
        next_pwr = irt_pkg::PW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      pwr <= irt_pkg::PW_RUN;
    end else begin
      pwr <= next_pwr;
    end
  end

  // Oscillator gate: nothing below advances in stop mode
  logic osc_en;
  assign osc_en      = (pwr != irt_pkg::PW_STOP); // RULE_15
  assign osc_running = osc_en;
  assign core_halted = (pwr != irt_pkg::PW_RUN);

  always_ff @(posedge clk) begin
    if (clr) begin
      core_wake <= 1'b0;
    end else begin
      core_wake <= (pwr != irt_pkg::PW_RUN)
                   && (next_pwr == irt_pkg::PW_RUN); // RULE_04
    end
  end

  // Machine cycle prescaler, free running so reloads stay aligned
  logic [irt_pkg::MC_W-1:0] mc_cnt;
  logic                     mc_tick;

  always_ff @(posedge clk) begin
    if (clr) begin
      mc_cnt <= '0;
    end else if (osc_en) begin
      mc_cnt <= mc_cnt + 1'b1; // RULE_02
    end
  end

  assign mc_tick = osc_en && (mc_cnt == irt_pkg::MC_LAST); // RULE_02

  // Timer: nine-bit down counter plus carrier latch
  irt_pkg::irt_tmr_s tmr;
  logic              step;

  assign step = mc_tick && running && ctrl.run; // RULE_16
  assign done = step && (tmr.count == '0);      // RULE_03

  always_ff @(posedge clk) begin
    if (clr) begin
      tmr <= irt_pkg::TMR_RST; // RULE_12
    end else if (wr_load) begin
      tmr <= hwdata[irt_pkg::TMR_W-1:0]; // RULE_18 RULE_01
    end else if (step && !done) begin
      tmr.count <= tmr.count - 1'b1; // RULE_02
    end
  end

  // Load of N gives N+1 machine cycles before completion
  always_ff @(posedge clk) begin
    if (clr) begin
      running <= 1'b0;
    end else if (wr_load) begin
      running <= 1'b1; // RULE_05
    end else if (done) begin
      running <= 1'b0; // RULE_03
    end
  end

  // Carrier generation and pin drive
  logic wave;
  logic emit;

  irt_carrier_gen u_car (
    .clk    (clk),
    .rst_n  (!clr),
    .osc_en (osc_en),
    .div12  (ctrl.carrier_freq_select),
    .wave   (wave)
  );

  // Gate is unrelated to carrier phase, so edge pulses may be cut
  assign emit = running && tmr.carrier_en && osc_en; // RULE_07 RULE_14

  always_ff @(posedge clk) begin
    if (clr) begin
      carrier_out_pin <= 1'b0; // RULE_12
    end else begin
      carrier_out_pin <= emit && wave; // RULE_07 RULE_08
    end
  end

  always_ff @(posedge clk) begin
    if (lvd) begin
      tx_active_n <= 1'b0; // RULE_13
    end else if (!rst_n) begin
      tx_active_n <= 1'b1; // RULE_12
    end else begin
      tx_active_n <= !emit; // RULE_09
    end
  end

  // Interrupt status, enable and clear
  logic [irt_pkg::IRQ_W-1:0] irq_sts;
  logic [irt_pkg::IRQ_W-1:0] irq_en;
  logic [irt_pkg::IRQ_W-1:0] irq_set;
  logic [irt_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set                    = '0;
    irq_set[irt_pkg::IRQ_DONE] = done;
    irq_set[irt_pkg::IRQ_STOP] = (pwr != irt_pkg::PW_STOP)
                                 && (next_pwr == irt_pkg::PW_STOP);
    irq_set[irt_pkg::IRQ_WAKE] = (pwr != irt_pkg::PW_RUN)
                                 && (next_pwr == irt_pkg::PW_RUN);
  end

  assign irq_clr = wr_iclr ? hwdata[irt_pkg::IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (clr) begin
      irq_sts <= irt_pkg::IRQ_RST;
    end else begin
      irq_sts <= (irq_sts & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      irq_en <= irt_pkg::IRQ_RST;
    end else if (wr_ien) begin
      irq_en <= hwdata[irt_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_sts & irq_en);

  // Read data, prepared in the address phase
  logic [irt_pkg::STS_W-1:0] status;
  logic [31:0]               next_rdata;

  assign status = {emit, running, osc_en, core_halted};

  // Forward a write in its data phase to a read right behind it
  logic [irt_pkg::CTRL_W-1:0] ctrl_fwd;
  logic [irt_pkg::TMR_W-1:0]  tmr_fwd;
  logic [irt_pkg::IRQ_W-1:0]  sts_fwd;
  logic [irt_pkg::IRQ_W-1:0]  en_fwd;

  assign ctrl_fwd = wr_ctrl ? hwdata[irt_pkg::CTRL_W-1:0] : ctrl;
  assign tmr_fwd  = wr_load ? hwdata[irt_pkg::TMR_W-1:0] : tmr;
  assign sts_fwd  = (irq_sts & ~irq_clr) | irq_set;
  assign en_fwd   = wr_ien ? hwdata[irt_pkg::IRQ_W-1:0] : irq_en;

  always_comb begin
    next_rdata = 32'h00000000;
    if (irt_hit(haddr, irt_pkg::OFF_CTRL)) begin
      next_rdata[irt_pkg::CTRL_W-1:0] = ctrl_fwd;
    end else if (irt_hit(haddr, irt_pkg::OFF_LOAD)) begin
      next_rdata[irt_pkg::TMR_W-1:0] = tmr_fwd;
    end else if (irt_hit(haddr, irt_pkg::OFF_STATUS)) begin
      next_rdata[irt_pkg::STS_W-1:0] = status;
    end else if (irt_hit(haddr, irt_pkg::OFF_IRQ_STS)) begin
      next_rdata[irt_pkg::IRQ_W-1:0] = sts_fwd;
    end else if (irt_hit(haddr, irt_pkg::OFF_IRQ_EN)) begin
      next_rdata[irt_pkg::IRQ_W-1:0] = en_fwd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule // irt_timer_top

`default_nettype wire

/* tb/irt_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none

module irt_timer_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic low_volt_reset,
  input wire logic carrier_out_pin,
  input wire logic tx_active_n,
  input wire logic core_halted,
  input wire logic core_wake,
  input wire logic osc_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence lvd_held;
    low_volt_reset [*4];
  endsequence
  sequence stop_held;
    !osc_running [*3];
  endsequence

  a_reset_pins: assert property (disable iff (1'b0)
    !rst_n ##1 !rst_n |-> !carrier_out_pin) else $error("carrier in reset");
  a_idle_low: assert property (tx_active_n |-> !carrier_out_pin)
    else $error("carrier while indicator high");
  a_lvd_indicator: assert property (lvd_held |=> !tx_active_n)
    else $error("indicator high in low-supply reset");
  a_stop_quiet: assert property (stop_held |->
    !carrier_out_pin && $stable(tx_active_n)) else $error("pins move in stop");
  a_stop_halts: assert property (!osc_running |-> core_halted)
    else $error("oscillator off but core running");
  a_wake_pulse: assert property (core_wake |=> !core_wake)
    else $error("wake longer than one cycle");
  a_wake_cause: assert property (core_wake |->
    $past(core_halted) || $past(core_halted, 2)) else $error("wake unhalted");
  a_carrier_toggles: assert property (
    not ((!tx_active_n && !low_volt_reset && $stable(carrier_out_pin))
         [*7]))
    else $error("carrier stuck while emitting");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
endmodule // irt_timer_props

`default_nettype wire

/* tb/irt_led_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Emitter and lamp; keeps widest carrier pulse of the current burst
module irt_led_model (
  // Clock
  input  wire logic clk,
  // Pins
  input  wire logic carrier_out_pin,
  input  wire logic tx_active_n,
  // Observation
  output int        hi_max
);
  int   run_len = 0;
  logic ind_q   = 1'b1;
  initial hi_max = 0;
  always @(posedge clk) begin
    ind_q <= tx_active_n;
    if (ind_q && !tx_active_n)
      hi_max <= 0;
    else if (!carrier_out_pin && run_len > hi_max)
      hi_max <= run_len;
    run_len <= carrier_out_pin ? run_len + 1 : 0;
  end
endmodule // irt_led_model

`default_nettype wire

/* tb/ir_carrier_transmit_timer_test.sv */
`timescale 1ns/1ps
`default_nettype none

module ir_carrier_transmit_timer_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        low_volt_reset = 1'b0;
  logic        wake_pin = 1'b0;
  logic [31:0] rd;
  wire logic [31:0] hrdata;
  wire logic   hreadyout, hresp, carrier_out_pin, tx_active_n;
  wire logic   core_halted, core_wake, osc_running, irq;
  int          hi_max, n, m_ctrl, m_en, lens[$] = '{0, 1, 3};
  int          fail_count = 0, check_count = 0, cyc = 0, seed = 70;

  irt_timer_top dut_u (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .low_volt_reset, .wake_pin, .carrier_out_pin, .tx_active_n,
    .core_halted, .core_wake, .osc_running, .irq);
  irt_led_model led_u (.clk, .carrier_out_pin, .tx_active_n, .hi_max);

  always #20 clk = ~clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Load count and latch, then count indicator-low cycles
  task automatic burst(input int nn, input logic en);
    bus(1'b1, irt_pkg::OFF_LOAD, {22'h0, en, nn[8:0]});
    n = 0;
    repeat (8 * nn + 24) begin
      @(posedge clk);
      n += (tx_active_n === 1'b0);
    end
  endtask

  task automatic wait_low(input logic want_wake);
    n = 0;
    while ((want_wake ? core_wake : !osc_running) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk(tx_active_n, 1'b1, "indicator");
    chk(carrier_out_pin, 1'b0, "carrier");
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      m_en = (a == irt_pkg::OFF_STATUS) ? 2 : 0;
      chk(rd, m_en, "reset value");
    end
    for (int i = 0; i < 4; i++) begin
      m_ctrl = $random(seed) & 32'h6;
      m_en = $random(seed) & 32'h7;
      bus(1'b1, irt_pkg::OFF_CTRL, m_ctrl);
      bus(1'b1, irt_pkg::OFF_IRQ_EN, m_en);
      bus(1'b1, 8'h1c, $random(seed));
      bus(1'b0, irt_pkg::OFF_CTRL, 32'h0);
      chk(rd, m_ctrl, "ctrl");
      bus(1'b0, irt_pkg::OFF_IRQ_EN, 32'h0);
      chk(rd, m_en, "irq enable");
    end
    bus(1'b1, irt_pkg::OFF_IRQ_EN, 32'h7);
    repeat (3) lens.push_back($random(seed) & 32'h1f);
    foreach (lens[i]) begin
      bus(1'b1, irt_pkg::OFF_CTRL, {30'h0, i[0], 1'b1});
      burst(lens[i], 1'b1);
      chk(n > 8 * lens[i] && n <= 8 * lens[i] + 8, 32'h1, "length");
      if (lens[i] > 2)
        chk(hi_max, i[0] ? 32'd6 : 32'd4, "pulse");
      chk(irq, 1'b1, "irq");
      bus(1'b0, irt_pkg::OFF_IRQ_STS, 32'h0);
      chk(rd, 32'h1, "done flag");
      bus(1'b1, irt_pkg::OFF_IRQ_CLR, 32'h7);
      @(negedge clk);
      chk(irq, 1'b0, "irq clear");
    end
    bus(1'b1, irt_pkg::OFF_IRQ_EN, 32'h0);
    burst(5, 1'b0);
    chk(n, 32'h0, "no carrier");
    chk(irq, 1'b0, "irq masked");
    bus(1'b1, irt_pkg::OFF_CTRL, 32'h0);
    burst(2, 1'b1);
    chk(n, 32'd39, "frozen");
    bus(1'b1, irt_pkg::OFF_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    chk(tx_active_n, 1'b1, "resumed end");
    bus(1'b1, irt_pkg::OFF_LOAD, 32'h204);
    bus(1'b1, irt_pkg::OFF_CMD, 32'h1);
    @(negedge clk);
    chk(core_halted, 1'b1, "halted");
    wait_low(1'b1);
    chk(core_wake, 1'b1, "wake");
    burst(4, 1'b1);
    chk(n > 32 && n <= 40, 32'h1, "reload");
    bus(1'b1, irt_pkg::OFF_CTRL, 32'h5);
    bus(1'b1, irt_pkg::OFF_LOAD, 32'h208);
    bus(1'b1, irt_pkg::OFF_CMD, 32'h1);
    @(negedge clk);
    chk(osc_running, 1'b1, "stop deferred");
    wait_low(1'b0);
    chk(osc_running, 1'b0, "stopped");
    @(posedge clk);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wake_pin <= 1'b0;
    chk(osc_running, 1'b1, "woken");
    bus(1'b0, irt_pkg::OFF_IRQ_STS, 32'h0);
    chk(rd, 32'h7, "event flags");
    low_volt_reset <= 1'b1;
    repeat (5) @(posedge clk);
    chk(tx_active_n, 1'b0, "low supply");
    low_volt_reset <= 1'b0;
    bus(1'b0, irt_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl cleared");
    complete_run();
  end
endmodule // ir_carrier_transmit_timer_test

bind irt_timer_top irt_timer_props props_u (.clk, .rst_n, .hreadyout, .hresp,
  .low_volt_reset, .carrier_out_pin, .tx_active_n, .core_halted, .core_wake,
  .osc_running);

`default_nettype wire
